/* File: design/bdm_addr_resolve.v */
// address resolution for the banked data memory: pointer redirection,
// bank choice and classification of the final location
// assumes pointer and bank values come from registers in the parent
`timescale 1ns/1ps
`include "bdm_map.vh"

module bdm_addr_resolve #(
  parameter LARGE_RAM = 1,
  parameter HAS_ADC   = 1
) (
  input  wire [7:0]            addr_in,
  input  wire [7:0]            ptr0_in,
  input  wire [7:0]            ptr1_in,
  input  wire                  bank_in,
  output reg  [7:0]            eff_addr_out,
  output reg                   eff_bank_out,
  output reg  [`BDM_CLS_W-1:0] cls_out
);

  wire [63:0] sfr_mask;
  reg         indirect;

  assign sfr_mask = (LARGE_RAM ? `BDM_SFR_MASK_LARGE : `BDM_SFR_MASK_SMALL)
                    & ~(HAS_ADC ? 64'h0 : `BDM_SFR_MASK_ADC);

  always @* begin
    indirect     = 1'b0;
    eff_addr_out = addr_in;
    eff_bank_out = 1'b0;
    if (addr_in == `BDM_ADDR_PORT0) begin
      indirect     = 1'b1;
      eff_addr_out = ptr0_in;
      eff_bank_out = 1'b0;
    end else if (addr_in == `BDM_ADDR_PORT1) begin
      indirect     = 1'b1;
      eff_addr_out = ptr1_in;
      eff_bank_out = bank_in;
    end
    cls_out = `BDM_CLS_NULL;
    if (indirect && (eff_addr_out == `BDM_ADDR_PORT0 ||
                     eff_addr_out == `BDM_ADDR_PORT1)) begin
      cls_out = `BDM_CLS_NULL;
    end else if (eff_addr_out == `BDM_ADDR_PTR0) begin
      cls_out = `BDM_CLS_PTR0;
    end else if (eff_addr_out == `BDM_ADDR_PTR1) begin
      cls_out = `BDM_CLS_PTR1;
    end else if (eff_addr_out == `BDM_ADDR_BANK) begin
      cls_out = `BDM_CLS_BANK;
    end else if (eff_addr_out[7]) begin
      // bank 1 general area does not exist
      if (!eff_bank_out && (LARGE_RAM || !eff_addr_out[6])) begin
        cls_out = `BDM_CLS_RAM;
      end else begin
        cls_out = `BDM_CLS_NULL;
      end
    end else if (eff_addr_out == `BDM_ADDR_EEC) begin
      cls_out = eff_bank_out ? `BDM_CLS_SFR : `BDM_CLS_NULL;
    end else if (!eff_addr_out[6] && sfr_mask[eff_addr_out[5:0]]) begin
      cls_out = `BDM_CLS_SFR;
    end else begin
      cls_out = `BDM_CLS_NULL;
    end
  end

endmodule

/* File: design/bdm_data_mem.v */
// banked data memory with direct and pointer based indirect access
// assumes one core request per clock at most and a peripheral bus that
// returns read data in the same cycle as its registered strobe
`timescale 1ns/1ps
`include "bdm_map.vh"

module bdm_data_mem #(
  parameter LARGE_RAM = 1,
  parameter HAS_ADC   = 1
) (
  input  wire       SYS_CLK_IN,
  input  wire       SRST_IN,
  input  wire       WDT_PD_RST_IN,
  input  wire       RD_EN_IN,
  input  wire       WR_EN_IN,
  input  wire [7:0] ADDR_IN,
  input  wire [7:0] WDATA_IN,
  output reg  [7:0] RDATA_OUT,
  output reg        RD_DONE_OUT,
  output reg        WR_DONE_OUT,
  output reg        BANK_OUT,
  output reg  [7:0] SFR_ADDR_OUT,
  output reg        SFR_BANK_OUT,
  output reg        SFR_RD_OUT,
  output reg        SFR_WR_OUT,
  output reg  [7:0] SFR_WDATA_OUT,
  input  wire [7:0] SFR_RDATA_IN
);

  // access pipeline: request stage and answer stage
  localparam ST_IDLE   = 3'b001;
  localparam ST_READ   = 3'b010;
  localparam ST_WRITE  = 3'b100;

  reg  [7:0]            ptr0_r;
  reg  [7:0]            ptr0_nxt;
  reg  [7:0]            ptr1_r;
  reg  [7:0]            ptr1_nxt;
  reg                   bank_r;
  reg                   bank_nxt;

  reg  [2:0]            stage_r;
  reg  [2:0]            stage_nxt;
  reg                   sfr_sel_r;
  reg                   sfr_sel_nxt;
  reg  [7:0]            loc_data_r;
  reg  [7:0]            loc_data_nxt;

  reg  [7:0]            sfr_addr_nxt;
  reg                   sfr_bank_nxt;
  reg                   sfr_rd_nxt;
  reg                   sfr_wr_nxt;
  reg  [7:0]            sfr_wdata_nxt;
  reg  [7:0]            rdata_nxt;
  reg                   rd_done_nxt;
  reg                   wr_done_nxt;

  wire [7:0]            eff_addr;
  wire                  eff_bank;
  wire [`BDM_CLS_W-1:0] cls;
  wire [7:0]            ram_rdata;
  wire                  ram_we;
  wire                  do_wr;
  wire                  do_rd;
  wire                  prot_hit;
  wire [63:0]           prot_mask;

  // a write and a read in the same cycle is taken as the write
  assign do_wr = WR_EN_IN;
  assign do_rd = RD_EN_IN & ~WR_EN_IN;

  bdm_addr_resolve #(
    .LARGE_RAM (LARGE_RAM),
    .HAS_ADC   (HAS_ADC)
  ) u_resolve (
    .addr_in      (ADDR_IN),
    .ptr0_in      (ptr0_r),
    .ptr1_in      (ptr1_r),
    .bank_in      (bank_r),
    .eff_addr_out (eff_addr),
    .eff_bank_out (eff_bank),
    .cls_out      (cls)
  );

  assign ram_we = do_wr & (cls == `BDM_CLS_RAM);

  bdm_gpr_ram u_ram (
    .clk_in    (SYS_CLK_IN),
    .we_in     (ram_we),
    .addr_in   (eff_addr[`BDM_GPR_AW-1:0]),
    .wdata_in  (WDATA_IN),
    .rdata_out (ram_rdata)
  );

  // the 40H register is never in the protect table
  assign prot_mask = `BDM_SFR_PROT_MASK;
  assign prot_hit  = ~eff_addr[6] & prot_mask[eff_addr[5:0]];

  // pointer and bank registers
  always @* begin
    ptr0_nxt = ptr0_r;
    ptr1_nxt = ptr1_r;
    bank_nxt = bank_r;
    if (do_wr) begin
      case (cls)
        `BDM_CLS_PTR0: begin
          ptr0_nxt = WDATA_IN;
        end
        `BDM_CLS_PTR1: begin
          ptr1_nxt = WDATA_IN;
        end
        `BDM_CLS_BANK: begin
          bank_nxt = WDATA_IN[`BDM_BANK_BIT];
        end
        default: begin
          bank_nxt = bank_r;
        end
      endcase
    end
  end

  // read value of locations held here, captured in the request cycle
  always @* begin
    loc_data_nxt = `BDM_READ_ZERO;
    case (cls)
      `BDM_CLS_PTR0: begin
        loc_data_nxt = ptr0_r;
      end
      `BDM_CLS_PTR1: begin
        loc_data_nxt = ptr1_r;
      end
      `BDM_CLS_BANK: begin
        loc_data_nxt = {7'h00, bank_r};
      end
      `BDM_CLS_RAM: begin
        loc_data_nxt = ram_rdata;
      end
      default: begin
        loc_data_nxt = `BDM_READ_ZERO;
      end
    endcase
  end

  // peripheral strobes and pipeline stage
  always @* begin
    stage_nxt     = ST_IDLE;
    sfr_sel_nxt   = 1'b0;
    sfr_addr_nxt  = SFR_ADDR_OUT;
    sfr_bank_nxt  = SFR_BANK_OUT;
    sfr_rd_nxt    = 1'b0;
    sfr_wr_nxt    = 1'b0;
    sfr_wdata_nxt = SFR_WDATA_OUT;
    if (do_wr) begin
      stage_nxt = ST_WRITE;
    end else if (do_rd) begin
      stage_nxt = ST_READ;
    end
    if ((do_wr | do_rd) && cls == `BDM_CLS_SFR) begin
      sfr_addr_nxt = eff_addr;
      sfr_bank_nxt = eff_bank;
      sfr_sel_nxt  = do_rd;
      sfr_rd_nxt   = do_rd;
      // protected locations still read, writes are swallowed
      sfr_wr_nxt   = do_wr & ~prot_hit;
      if (do_wr) begin
        sfr_wdata_nxt = WDATA_IN;
      end
    end
  end

  // answer stage: one clock after the request, two to the data
  always @* begin
    rdata_nxt   = RDATA_OUT;
    rd_done_nxt = 1'b0;
    wr_done_nxt = 1'b0;
    case (stage_r)
      ST_READ: begin
        rdata_nxt   = sfr_sel_r ? SFR_RDATA_IN : loc_data_r;
        rd_done_nxt = 1'b1;
      end
      ST_WRITE: begin
        wr_done_nxt = 1'b1;
      end
      ST_IDLE: begin
        rd_done_nxt = 1'b0;
      end
      default: begin
        rd_done_nxt = 1'b0;
      end
    endcase
  end

  always @(posedge SYS_CLK_IN) begin
    if (SRST_IN) begin
      ptr0_r        <= `BDM_PTR_RESET;
      ptr1_r        <= `BDM_PTR_RESET;
      stage_r       <= ST_IDLE;
      sfr_sel_r     <= 1'b0;
      loc_data_r    <= `BDM_READ_ZERO;
      RDATA_OUT     <= `BDM_READ_ZERO;
      RD_DONE_OUT   <= 1'b0;
      WR_DONE_OUT   <= 1'b0;
      SFR_ADDR_OUT  <= `BDM_ADDR_SFR_BASE;
      SFR_BANK_OUT  <= 1'b0;
      SFR_RD_OUT    <= 1'b0;
      SFR_WR_OUT    <= 1'b0;
      SFR_WDATA_OUT <= `BDM_READ_ZERO;
    end else begin
      ptr0_r        <= ptr0_nxt;
      ptr1_r        <= ptr1_nxt;
      stage_r       <= stage_nxt;
      sfr_sel_r     <= sfr_sel_nxt;
      loc_data_r    <= loc_data_nxt;
      RDATA_OUT     <= rdata_nxt;
      RD_DONE_OUT   <= rd_done_nxt;
      WR_DONE_OUT   <= wr_done_nxt;
      SFR_ADDR_OUT  <= sfr_addr_nxt;
      SFR_BANK_OUT  <= sfr_bank_nxt;
      SFR_RD_OUT    <= sfr_rd_nxt;
      SFR_WR_OUT    <= sfr_wr_nxt;
      SFR_WDATA_OUT <= sfr_wdata_nxt;
    end
  end

  // bank survives a watchdog reset taken while powered down
  always @(posedge SYS_CLK_IN) begin
    if (SRST_IN && !WDT_PD_RST_IN) begin
      bank_r   <= `BDM_BANK_RESET;
      BANK_OUT <= `BDM_BANK_RESET;
    end else if (SRST_IN) begin
      bank_r   <= bank_r;
      BANK_OUT <= bank_r;
    end else begin
      bank_r   <= bank_nxt;
      BANK_OUT <= bank_nxt;
    end
  end

endmodule

/* File: design/bdm_gpr_ram.v */
// general purpose byte array, bank 0, 128 entries
// assumes the parent only raises the write enable for addresses it has classed as ram
`timescale 1ns/1ps
`include "bdm_map.vh"

module bdm_gpr_ram (
  input  wire                   clk_in,
  input  wire                   we_in,
  input  wire [`BDM_GPR_AW-1:0] addr_in,
  input  wire [7:0]             wdata_in,
  output wire [7:0]             rdata_out
);

  // no reset: contents are volatile and undefined after power up
  reg [7:0] mem [0:`BDM_GPR_DEPTH-1];

  always @(posedge clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end

  // asynchronous read keeps the whole access inside the pipeline slot
  assign rdata_out = mem[addr_in];

endmodule

/* File: design/bdm_map.vh */
// constants for the banked data memory: addresses, masks, reset values
// assumes an 8-bit data memory address space seen by the processor core
`ifndef BDM_MAP_VH
`define BDM_MAP_VH

// fixed addresses of the locations decoded by this block
`define BDM_ADDR_PORT0     8'h00
`define BDM_ADDR_PTR0      8'h01
`define BDM_ADDR_PORT1     8'h02
`define BDM_ADDR_PTR1      8'h03
`define BDM_ADDR_BANK      8'h04
`define BDM_ADDR_EEC       8'h40
`define BDM_ADDR_SFR_BASE  8'h00

// general purpose area, bank 0 only
`define BDM_GPR_BASE       8'h80
`define BDM_GPR_END_SMALL  8'hBF
`define BDM_GPR_END_LARGE  8'hFF
`define BDM_GPR_DEPTH      128
`define BDM_GPR_AW         7

// bank select field
`define BDM_BANK_BIT       0
`define BDM_BANK_RESET     1'b0
`define BDM_PTR_RESET      8'h00

// one bit per address 00H..3FH held by peripherals outside this block
`define BDM_SFR_MASK_SMALL 64'hE03F80FF_CFFFFFE0
`define BDM_SFR_MASK_LARGE 64'hE03FFFFF_CFFFFFE0
// analog converter registers 20H..24H
`define BDM_SFR_MASK_ADC   64'h0000001F_00000000
// locations that ignore processor writes (table high byte)
`define BDM_SFR_PROT_MASK  64'h00000000_00000100

// one-hot class of a resolved access
`define BDM_CLS_W          6
`define BDM_CLS_NULL       6'h01
`define BDM_CLS_PTR0       6'h02
`define BDM_CLS_PTR1       6'h04
`define BDM_CLS_BANK       6'h08
`define BDM_CLS_SFR        6'h10
`define BDM_CLS_RAM        6'h20

`define BDM_READ_ZERO      8'h00

`endif

/* File: test/bdm_data_mem_props.sv */
// concurrent checks on the banked data memory core and peripheral ports
// assumes a single clock domain with synchronous active high reset
`timescale 1ns/1ps
module bdm_data_mem_props (
  input wire logic       SYS_CLK_IN,
  input wire logic       SRST_IN,
  input wire logic       WDT_PD_RST_IN,
  input wire logic       RD_EN_IN,
  input wire logic       WR_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic       RD_DONE_OUT,
  input wire logic       WR_DONE_OUT,
  input wire logic       BANK_OUT,
  input wire logic [7:0] SFR_ADDR_OUT,
  input wire logic       SFR_BANK_OUT,
  input wire logic       SFR_RD_OUT,
  input wire logic       SFR_WR_OUT,
  input wire logic [7:0] SFR_RDATA_IN
);
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (SRST_IN);
  wire rd_q = RD_EN_IN && !WR_EN_IN;
  a_rd_done_lat: assert property (rd_q |-> ##2 RD_DONE_OUT)
    else $error("read answer late");
  a_wr_done_lat: assert property (WR_EN_IN |-> ##2 WR_DONE_OUT)
    else $error("write answer late");
  a_no_spur_done: assert property (RD_DONE_OUT |-> $past(rd_q, 2))
    else $error("read answer without request");
  a_bank_write: assert property (WR_EN_IN && ADDR_IN == 8'h04
    |=> BANK_OUT == $past(WDATA_IN[0])) else $error("bank bit wrong");
  a_bank_reset: assert property (disable iff (1'b0)
    SRST_IN && !WDT_PD_RST_IN |=> !BANK_OUT)
    else $error("bank not cleared by reset");
  a_bank_keep: assert property (disable iff (1'b0)
    SRST_IN && WDT_PD_RST_IN |=> BANK_OUT == $past(BANK_OUT))
    else $error("bank lost in watchdog reset");
  a_prot_write: assert property (WR_EN_IN && ADDR_IN == 8'h08
    |=> !SFR_WR_OUT) else $error("protected write reached peripheral");
  a_sfr_direct: assert property (rd_q && ADDR_IN == 8'h05
    |=> SFR_RD_OUT && SFR_ADDR_OUT == 8'h05 && !SFR_BANK_OUT)
    else $error("direct peripheral read wrong");
  a_null_zero: assert property (rd_q && ADDR_IN[7:6] == 2'b01
    && ADDR_IN != 8'h40 |-> ##2 RDATA_OUT == 8'h00)
    else $error("unused read not zero");
  a_ram_local: assert property ((RD_EN_IN || WR_EN_IN) && ADDR_IN[7]
    |=> !SFR_RD_OUT && !SFR_WR_OUT) else $error("ram went outside");
  a_sfr_return: assert property (SFR_RD_OUT
    |=> RD_DONE_OUT && RDATA_OUT == $past(SFR_RDATA_IN))
    else $error("peripheral data lost");
  c_bank1: cover property (SFR_RD_OUT && SFR_BANK_OUT);
  c_rd: cover property (RD_DONE_OUT);
  c_wr: cover property (SFR_WR_OUT);
endmodule
bind bdm_data_mem bdm_data_mem_props u_props (
  .SYS_CLK_IN(SYS_CLK_IN), .SRST_IN(SRST_IN),
  .WDT_PD_RST_IN(WDT_PD_RST_IN), .RD_EN_IN(RD_EN_IN),
  .WR_EN_IN(WR_EN_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .RDATA_OUT(RDATA_OUT), .RD_DONE_OUT(RD_DONE_OUT),
  .WR_DONE_OUT(WR_DONE_OUT), .BANK_OUT(BANK_OUT),
  .SFR_ADDR_OUT(SFR_ADDR_OUT), .SFR_BANK_OUT(SFR_BANK_OUT),
  .SFR_RD_OUT(SFR_RD_OUT), .SFR_WR_OUT(SFR_WR_OUT),
  .SFR_RDATA_IN(SFR_RDATA_IN));

/* File: test/bdm_sfr_model.sv */
// peripheral register model behind the special function area
// assumes strobes are one cycle and read data is used in the strobe cycle
`timescale 1ns/1ps
module bdm_sfr_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] addr_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] regs [0:127];
  logic [7:0] last;
  initial begin
    for (int i = 0; i < 128; i++) regs[i] = 8'h00;
    last = 8'h00;
  end
  always @(posedge clk_in) begin
    if (wr_in) regs[addr_in[6:0]] <= wdata_in;
    if (rd_in) last <= regs[addr_in[6:0]];
  end
  // outside a strobe the bus shows junk, never the last value
  assign rdata_out = rd_in ? regs[addr_in[6:0]] : ~last;
endmodule

/* File: test/test_banked_data_memory_indirect_access.sv */
// self-checking bench for the banked data memory, large converterless part
// assumes the peripheral model answers in the strobe cycle
`timescale 1ns/1ps
module test_banked_data_memory_indirect_access;
  logic clk, srst, wdt, rd_en, wr_en, rdone, wdone, bank, srd, swr, sbank;
  logic [7:0] addr, wdata, rdata, saddr, swdata, srdata;
  int mismatches = 0;
  int tests_run = 0;
  bdm_data_mem #(.LARGE_RAM(1), .HAS_ADC(0)) bdm_data_mem_inst (
    .SYS_CLK_IN(clk), .SRST_IN(srst), .WDT_PD_RST_IN(wdt),
    .RD_EN_IN(rd_en), .WR_EN_IN(wr_en), .ADDR_IN(addr), .WDATA_IN(wdata),
    .RDATA_OUT(rdata), .RD_DONE_OUT(rdone), .WR_DONE_OUT(wdone),
    .BANK_OUT(bank), .SFR_ADDR_OUT(saddr), .SFR_BANK_OUT(sbank),
    .SFR_RD_OUT(srd), .SFR_WR_OUT(swr), .SFR_WDATA_OUT(swdata),
    .SFR_RDATA_IN(srdata));
  bdm_sfr_model bdm_sfr_model_inst (.clk_in(clk), .addr_in(saddr),
    .rd_in(srd), .wr_in(swr), .wdata_in(swdata), .rdata_out(srdata));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task close_out;
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task wait_done(input bit w);
    int i;
    i = 0;
    while ((w ? wdone : rdone) !== 1'b1 && i < 6) begin
      @(posedge clk) #1;
      i++;
    end
    if (i == 6) begin
      mismatches++;
      $display("FAIL answer expected 1 seen 0");
      close_out;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1; addr <= a; wdata <= d;
    @(posedge clk);
    wr_en <= 0;
    #1 wait_done(1);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd_en <= 1; addr <= a;
    @(posedge clk);
    rd_en <= 0;
    #1 wait_done(0);
    chk("rdata", e, rdata);
  endtask
  task rst(input logic w, input int n);
    @(posedge clk);
    srst <= 1; wdt <= w;
    repeat (n) @(posedge clk);
    srst <= 0; wdt <= 0;
    @(posedge clk) #1;
  endtask
  initial begin
    srst = 1; wdt = 0; rd_en = 0; wr_en = 0; addr = 0; wdata = 0;
    rst(0, 20);
    chk("bank", 8'h00, {7'h0, bank});
    rd(8'h04, 8'h00);
    $display("test reset done");
    wr(8'h80, 8'hA5);
    wr(8'hFF, 8'h5A);
    rd(8'h80, 8'hA5);
    rd(8'hFF, 8'h5A);
    $display("test ram done");
    wr(8'h01, 8'h81);
    rd(8'h01, 8'h81);
    wr(8'h00, 8'h3C);
    rd(8'h81, 8'h3C);
    wr(8'h01, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h90, 8'h11);
    wr(8'h03, 8'h90);
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h01);
    chk("bank", 8'h01, {7'h0, bank});
    rd(8'h90, 8'h11);
    rd(8'h02, 8'h00);
    wr(8'h02, 8'h22);
    wr(8'h03, 8'h40);
    wr(8'h02, 8'h77);
    rd(8'h02, 8'h77);
    rd(8'h40, 8'h00);
    wr(8'h04, 8'h00);
    wr(8'h03, 8'h90);
    rd(8'h02, 8'h11);
    $display("test indirect done");
    wr(8'h05, 8'h5A);
    rd(8'h05, 8'h5A);
    wr(8'h08, 8'h99);
    rd(8'h08, 8'h00);
    wr(8'h1C, 8'hFF);
    rd(8'h1C, 8'h00);
    wr(8'h50, 8'hC3);
    rd(8'h50, 8'h00);
    wr(8'h20, 8'h55);
    rd(8'h20, 8'h00);
    $display("test sfr done");
    wr(8'h04, 8'h01);
    rst(1, 2);
    chk("bank", 8'h01, {7'h0, bank});
    rst(0, 2);
    chk("bank", 8'h00, {7'h0, bank});
    $display("test wdt done");
    close_out;
  end
endmodule
